// [common/irq_arb_pkg.sv]
// constants, register map and types for the interrupt arbiter
// assumes a single 32-bit ahb-lite slave region decoded on haddr[7:0]
package irq_arb_pkg;
    // geometry of bids and sources
    localparam int BID_W = 10;
    localparam int CH_N = 4;
    localparam int TYPE_N = 6;
    localparam int SRC_N = 24;
    localparam int THR_W = 7;
    localparam int LVL_W = 4;
    localparam int PRIO_W = 3;
    localparam int CH_W = 3;
    localparam int BYTE_W = 8;
    localparam int THR_LSB = 3;
    // arbitration timing: 10 bit steps inside a 22 clock cycle
    localparam int SCAN_BITS = 10;
    localparam int SCAN_PERIOD = 22;
    localparam logic [4:0] SCAN_LAST = 5'(SCAN_PERIOD - 1);
    // source type index, low bits of the source number are the channel
    localparam int T_RX = 0;
    localparam int T_TX = 1;
    localparam int T_BRK = 2;
    localparam int T_COS = 3;
    localparam int T_FLOW = 4;
    localparam int T_ADDR = 5;
    // type codes placed in bid bits 6:3
    localparam logic [3:0] CODE_BRK = 4'h2;
    localparam logic [3:0] CODE_COS = 4'h6;
    localparam logic [3:0] CODE_FLOW = 4'h7;
    localparam logic [3:0] CODE_ADDR = 4'h3;
    localparam logic [1:0] RX_TAIL = 2'h1;
    localparam logic [1:0] TX_TAIL = 2'h0;
    // register byte offsets
    localparam logic [7:0] OFS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_MASK = 8'h04;
    localparam logic [7:0] OFS_VBASE = 8'h08;
    localparam logic [7:0] OFS_PRIO = 8'h0c;
    localparam logic [7:0] OFS_CAPTURED = 8'h10;
    localparam logic [7:0] OFS_GRX = 8'h14;
    localparam logic [7:0] OFS_GTX = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1c;
    // control fields and status layout
    localparam int CTL_MODE_LSB = 7;
    localparam int CTL_W = 9;
    localparam int PRIO_REG_W = 12;
    localparam int STAT_IRQ_BIT = 16;
    // reset values and the word transfer size
    localparam logic [8:0] CONTROL_RST = 9'h000;
    localparam logic [23:0] MASK_RST = 24'h000000;
    localparam logic [7:0] VBASE_RST = 8'h00;
    localparam logic [11:0] PRIO_RST = 12'h000;
    localparam logic [2:0] SIZE_WORD = 3'h2;
    // vector modification modes
    typedef enum logic [1:0] {
        VEC_FIXED, VEC_TYPE, VEC_CHAN, VEC_BOTH
    } vec_mode_type;
    // bus slave phases
    typedef enum logic [1:0] {
        BUS_IDLE, BUS_WAIT, BUS_DONE
    } bus_phase_type;
endpackage : irq_arb_pkg

// [core/bid_scanner.sv]
// bit-serial arbiter over 24 bids and the threshold
// assumes bids and valid come from logic on the same clock
`timescale 1ns/1ps
module bid_scanner (
    input wire logic clk,
    input wire logic rst,
    input wire logic [239:0] bids,
    input wire logic [23:0] bid_valid,
    input wire logic [6:0] threshold,
    output logic [9:0] result,
    output logic result_done
);
    typedef struct packed {
        logic [4:0] cnt;
        logic [239:0] snap;
        logic [6:0] thr;
        logic [24:0] alive;
        logic [9:0] result;
        logic done;
    } scan_state_type;

    scan_state_type s_reg, s_next;
    logic [3:0] bitpos;
    logic [24:0] col;
    logic [9:0] thr_ext;
    logic [9:0] win;

    // step 0 snapshots, steps 1..10 test bits 9..0, step 21 publishes
    always_comb begin
        s_next = s_reg;
        s_next.done = 1'b0;
        bitpos = 4'(5'(irq_arb_pkg::SCAN_BITS) - s_reg.cnt);
        thr_ext = {s_reg.thr, 3'h0};
        col = '0;
        win = '0;
        for (int i = 0; i < irq_arb_pkg::SRC_N; i++) begin
            col[i] = s_reg.snap[i * irq_arb_pkg::BID_W + 32'(bitpos)];
            if (s_reg.alive[i]) begin
                win = win | s_reg.snap[i * irq_arb_pkg::BID_W +: 10];
            end
        end
        col[irq_arb_pkg::SRC_N] = thr_ext[bitpos];
        if (s_reg.cnt == irq_arb_pkg::SCAN_LAST) begin
            s_next.cnt = '0;
            s_next.result = win;
            s_next.done = 1'b1;
        end else begin
            s_next.cnt = 5'(s_reg.cnt + 5'h1);
        end
        if (s_reg.cnt == '0) begin
            // later changes wait for the next cycle
            s_next.snap = bids;
            s_next.thr = threshold;
            s_next.alive = {1'b1, bid_valid};
        end else if (s_reg.cnt <= 5'(irq_arb_pkg::SCAN_BITS)) begin
            // drop every bidder showing 0 where another shows 1
            if (|(col & s_reg.alive)) begin
                s_next.alive = s_reg.alive & col;
            end
            // threshold still standing means no bid is strictly above it
            if (32'(bitpos) == irq_arb_pkg::THR_LSB &&
                s_next.alive[irq_arb_pkg::SRC_N]) begin
                s_next.alive = '0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign result = s_reg.result;
    assign result_done = s_reg.done;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    scan_period_a: assert property (
        s_reg.done |-> ##1 !s_reg.done ##21 s_reg.done)
        else $error("arbitration period is not 22 cycles");
    snap_hold_a: assert property (
        s_reg.cnt != '0 |=> $stable(s_reg.snap))
        else $error("snapshot changed inside a cycle");
    above_thr_a: assert property (
        s_reg.done && s_reg.result != '0 |->
        s_reg.result[9:3] > s_reg.thr)
        else $error("winner not above threshold");
    masked_out_a: assert property (
        s_reg.cnt == '0 && bid_valid == '0 |->
        ##22 (s_reg.done && s_reg.result == '0))
        else $error("disabled source produced a winner");
    scan_win_c: cover property (s_reg.done && s_reg.result != '0);
endmodule : bid_scanner

// [core/multichannel_interrupt_arbiter.sv]
// interrupt arbiter of a four channel serial controller
// assumes an ahb-lite master on clk and fifo status on the same clock
// Overview of operation
// - only enabled sources compete against the threshold
// - bid is channel, type, fill level, priority
// - request only while a bid exceeds threshold
// - capture loads the currently prevailing bid
// - captured word holds channel, type, level, error
// - 10 bit scan, result every 22 cycles
// - bid changes count in the next cycle
// - other sources take priority from software field
// - receiver fill, transmitter empty count lead bids
// - acknowledge fall captures last completed result
// - acknowledge returns fixed or modified vector
// - captured word holds until next capture
// - global ports address the captured channel
// - capture with nothing pending loads zero
// - update write captures, later read returns word
// - threshold bits compare against bid bits 9:3
// - type codes sit in bid bits 6:3
// - channel bits break ties, highest code wins
// - masked sources never request or get captured
`timescale 1ns/1ps
module multichannel_interrupt_arbiter (
    input wire logic clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [15:0] rx_level,
    input wire logic [3:0] rx_bidding,
    input wire logic [3:0] rx_error,
    input wire logic [15:0] tx_level,
    input wire logic [3:0] tx_bidding,
    input wire logic [3:0] break_change,
    input wire logic [3:0] input_change,
    input wire logic [3:0] flow_event,
    input wire logic [3:0] address_match,
    input wire logic [31:0] rx_port_data,
    output logic [3:0] rx_pop,
    output logic [3:0] tx_push,
    output logic [7:0] tx_port_data,
    input wire logic interrupt_acknowledge_in,
    output logic host_interrupt_request,
    output logic [7:0] vector_out,
    output logic vector_valid
);
    typedef struct packed {
        irq_arb_pkg::bus_phase_type phase;
        logic [7:0] addr;
        logic wr;
        logic size_ok;
        logic [8:0] interrupt_control_reg;
        logic [23:0] source_enable_mask;
        logic [7:0] vector_base_reg;
        logic [11:0] bid_priority_field_reg;
        logic [9:0] captured_interrupt_word;
        logic [31:0] rdata;
        logic irq_n;
        logic [7:0] vector;
        logic vector_valid;
        logic ack_meta;
        logic ack_sync;
        logic ack_prev;
        logic [3:0] push;
        logic [7:0] push_data;
    } arb_state_type;

    arb_state_type s_reg, s_next;
    logic [239:0] bids;
    logic [23:0] bid_active;
    logic [9:0] sc_result;
    logic take;
    logic data_wr;
    logic data_rd;
    logic update_cmd;
    logic ack_fall;
    logic [1:0] cur_ch;
    irq_arb_pkg::vec_mode_type vec_mode;

    // bid for a source whose high bits come from software
    function automatic logic [9:0] prog_bid(
        input logic [2:0] prio,
        input logic [3:0] code,
        input logic [1:0] ch
    );
        prog_bid = {prio, code, 1'b0, ch};
    endfunction : prog_bid

    // vector returned in the acknowledge cycle
    function automatic logic [7:0] make_vector(
        input irq_arb_pkg::vec_mode_type mode,
        input logic [7:0] base,
        input logic [9:0] word
    );
        case (mode)
            irq_arb_pkg::VEC_TYPE: make_vector = {base[7:4], word[6:3]};
            irq_arb_pkg::VEC_CHAN: make_vector = {base[7:3], word[2:0]};
            irq_arb_pkg::VEC_BOTH: make_vector = {base[7], word[6:0]};
            default: make_vector = base;
        endcase
    endfunction : make_vector

    // one-hot select of a channel
    function automatic logic [3:0] ch_onehot(input logic [1:0] ch);
        ch_onehot = 4'(4'h1 << ch);
    endfunction : ch_onehot

    // bids of all 24 sources, source number is type times four plus channel
    always_comb begin
        bids = '0;
        for (int c = 0; c < irq_arb_pkg::CH_N; c++) begin
            // receiver: filled count leads, error flag in bit 5
            bids[(irq_arb_pkg::T_RX * 4 + c) * 10 +: 10] = {
                rx_level[c * 4 +: 4], rx_error[c],
                irq_arb_pkg::RX_TAIL, 1'b0, 2'(c)};
            // transmitter: empty count one bit lower than receiver
            bids[(irq_arb_pkg::T_TX * 4 + c) * 10 +: 10] = {
                1'b0, tx_level[c * 4 +: 4],
                irq_arb_pkg::TX_TAIL, 1'b0, 2'(c)};
            bids[(irq_arb_pkg::T_BRK * 4 + c) * 10 +: 10] = prog_bid(
                s_reg.bid_priority_field_reg[0 +: 3],
                irq_arb_pkg::CODE_BRK, 2'(c));
            bids[(irq_arb_pkg::T_COS * 4 + c) * 10 +: 10] = prog_bid(
                s_reg.bid_priority_field_reg[3 +: 3],
                irq_arb_pkg::CODE_COS, 2'(c));
            bids[(irq_arb_pkg::T_FLOW * 4 + c) * 10 +: 10] = prog_bid(
                s_reg.bid_priority_field_reg[6 +: 3],
                irq_arb_pkg::CODE_FLOW, 2'(c));
            bids[(irq_arb_pkg::T_ADDR * 4 + c) * 10 +: 10] = prog_bid(
                s_reg.bid_priority_field_reg[9 +: 3],
                irq_arb_pkg::CODE_ADDR, 2'(c));
        end
    end

    // only sources both active and enabled may bid
    assign bid_active = {address_match, flow_event, input_change,
                         break_change, tx_bidding, rx_bidding}
                        & s_reg.source_enable_mask;

    bid_scanner scanner (
        .clk(clk),
        .rst(rst),
        .bids(bids),
        .bid_valid(bid_active),
        .threshold(s_reg.interrupt_control_reg[6:0]),
        .result(sc_result),
        .result_done()
    );

    // bus decode and capture events
    assign take = hsel && htrans[1] && hready;
    assign data_wr = s_reg.phase == irq_arb_pkg::BUS_WAIT &&
                     s_reg.wr && s_reg.size_ok;
    assign data_rd = s_reg.phase == irq_arb_pkg::BUS_WAIT &&
                     !s_reg.wr && s_reg.size_ok;
    assign update_cmd = data_wr &&
                        s_reg.addr == irq_arb_pkg::OFS_CAPTURED;
    assign ack_fall = s_reg.ack_prev && !s_reg.ack_sync;
    assign cur_ch = s_reg.captured_interrupt_word[1:0];
    assign vec_mode = irq_arb_pkg::vec_mode_type'(
        s_reg.interrupt_control_reg[8:7]);

    // next state: bus slave with one wait state, capture, vector
    always_comb begin
        s_next = s_reg;
        s_next.push = '0;
        // acknowledge pin is asynchronous, two stages then edge detect
        s_next.ack_meta = interrupt_acknowledge_in;
        s_next.ack_sync = s_reg.ack_meta;
        s_next.ack_prev = s_reg.ack_sync;
        case (s_reg.phase)
            irq_arb_pkg::BUS_IDLE, irq_arb_pkg::BUS_DONE: begin
                if (take) begin
                    s_next.phase = irq_arb_pkg::BUS_WAIT;
                    s_next.addr = haddr[7:0];
                    s_next.wr = hwrite;
                    s_next.size_ok = hsize == irq_arb_pkg::SIZE_WORD;
                end else begin
                    s_next.phase = irq_arb_pkg::BUS_IDLE;
                end
            end
            irq_arb_pkg::BUS_WAIT: begin
                // the wait state lets a read see a write just done
                s_next.phase = irq_arb_pkg::BUS_DONE;
            end
            default: begin
                s_next.phase = irq_arb_pkg::BUS_IDLE;
            end
        endcase
        // writes land at the edge that ends the wait cycle
        if (data_wr) begin
            case (s_reg.addr)
                irq_arb_pkg::OFS_CONTROL:
                    s_next.interrupt_control_reg = hwdata[8:0];
                irq_arb_pkg::OFS_MASK:
                    s_next.source_enable_mask = hwdata[23:0];
                irq_arb_pkg::OFS_VBASE:
                    s_next.vector_base_reg = hwdata[7:0];
                irq_arb_pkg::OFS_PRIO:
                    s_next.bid_priority_field_reg = hwdata[11:0];
                irq_arb_pkg::OFS_GTX: begin
                    s_next.push = ch_onehot(cur_ch);
                    s_next.push_data = hwdata[7:0];
                end
                default: begin
                end
            endcase
        end
        if (data_rd) begin
            case (s_reg.addr)
                irq_arb_pkg::OFS_CONTROL:
                    s_next.rdata = 32'(s_reg.interrupt_control_reg);
                irq_arb_pkg::OFS_MASK:
                    s_next.rdata = 32'(s_reg.source_enable_mask);
                irq_arb_pkg::OFS_VBASE:
                    s_next.rdata = 32'(s_reg.vector_base_reg);
                irq_arb_pkg::OFS_PRIO:
                    s_next.rdata = 32'(s_reg.bid_priority_field_reg);
                irq_arb_pkg::OFS_CAPTURED:
                    s_next.rdata = 32'(s_reg.captured_interrupt_word);
                irq_arb_pkg::OFS_GRX:
                    s_next.rdata = 32'(rx_port_data[32'(cur_ch) * 8 +: 8]);
                irq_arb_pkg::OFS_STATUS:
                    s_next.rdata = 32'(sc_result) |
                        (32'(!s_reg.irq_n) << irq_arb_pkg::STAT_IRQ_BIT);
                default: s_next.rdata = '0;
            endcase
        end
        // both capture paths take the last completed scan only
        if (update_cmd || ack_fall) begin
            s_next.captured_interrupt_word = sc_result;
        end
        if (ack_fall) begin
            s_next.vector = make_vector(vec_mode, s_reg.vector_base_reg,
                                        sc_result);
            s_next.vector_valid = 1'b1;
        end else if (s_reg.ack_sync) begin
            s_next.vector_valid = 1'b0;
        end
        // a zero result means nothing beat the threshold
        s_next.irq_n = sc_result == '0;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_reg <= '0;
            s_reg.phase <= irq_arb_pkg::BUS_IDLE;
            s_reg.interrupt_control_reg <= irq_arb_pkg::CONTROL_RST;
            s_reg.source_enable_mask <= irq_arb_pkg::MASK_RST;
            s_reg.vector_base_reg <= irq_arb_pkg::VBASE_RST;
            s_reg.bid_priority_field_reg <= irq_arb_pkg::PRIO_RST;
            s_reg.irq_n <= 1'b1;
            // stages start at the released level so that no false
            // acknowledge edge follows reset
            s_reg.ack_meta <= 1'b1;
            s_reg.ack_sync <= 1'b1;
            s_reg.ack_prev <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    // outputs; pop is a handshake and may be combinational
    assign hrdata = s_reg.rdata;
    assign hreadyout = s_reg.phase != irq_arb_pkg::BUS_WAIT;
    assign hresp = 1'b0;
    assign rx_pop = (data_rd && s_reg.addr == irq_arb_pkg::OFS_GRX)
                    ? ch_onehot(cur_ch) : 4'h0;
    assign tx_push = s_reg.push;
    assign tx_port_data = s_reg.push_data;
    assign host_interrupt_request = s_reg.irq_n;
    assign vector_out = s_reg.vector;
    assign vector_valid = s_reg.vector_valid;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    irq_follows_scan_a: assert property (
        1'b1 |=> host_interrupt_request == ($past(sc_result) == '0))
        else $error("request does not follow scan result");
    ack_capture_a: assert property (
        ack_fall |=> s_reg.captured_interrupt_word == $past(sc_result))
        else $error("acknowledge did not capture result");
    update_capture_a: assert property (
        update_cmd |=> s_reg.captured_interrupt_word == $past(sc_result))
        else $error("update command did not capture result");
    word_hold_a: assert property (
        !(update_cmd || ack_fall) |=>
        $stable(s_reg.captured_interrupt_word))
        else $error("captured word changed without capture");
    zero_capture_a: assert property (
        (update_cmd || ack_fall) && sc_result == '0 |=>
        s_reg.captured_interrupt_word == '0)
        else $error("empty capture not zero");
    fixed_vector_a: assert property (
        ack_fall && vec_mode == irq_arb_pkg::VEC_FIXED |=>
        vector_valid && vector_out == $past(s_reg.vector_base_reg))
        else $error("fixed vector mismatch");
    pop_route_a: assert property (
        rx_pop != '0 |-> !hreadyout && $onehot(rx_pop) &&
        rx_pop[cur_ch])
        else $error("pop not routed to captured channel");
    bus_timing_a: assert property (
        take |=> !hreadyout ##1 hreadyout)
        else $error("slave wait state wrong");

    // port pulses last one cycle and go to the captured channel
    pop_once_a: assert property (
        rx_pop != '0 |=> rx_pop == '0)
        else $error("receive pop longer than one cycle");

    push_route_a: assert property (
        tx_push != '0 |-> tx_push == ch_onehot($past(cur_ch)))
        else $error("push not routed to captured channel");

    // modified vectors carry codes of the word just captured; a
    // wrong code would send the host to the wrong service routine
    type_vector_a: assert property (
        ack_fall && vec_mode == irq_arb_pkg::VEC_TYPE |=>
        vector_out[3:0] == $past(sc_result[6:3]))
        else $error("type code missing from vector");

    chan_vector_a: assert property (
        ack_fall && vec_mode == irq_arb_pkg::VEC_CHAN |=>
        vector_out[2:0] == $past(sc_result[2:0]))
        else $error("channel code missing from vector");

    valid_release_a: assert property (
        vector_valid && s_reg.ack_sync |=> !vector_valid)
        else $error("vector valid outlived acknowledge");

    ack_cap_c: cover property (ack_fall && sc_result != '0);
    update_c: cover property (update_cmd && sc_result != '0);
    irq_c: cover property ($fell(host_interrupt_request));
    push_c: cover property (tx_push != '0);
endmodule : multichannel_interrupt_arbiter

// [test/host_model.sv]
// host cpu model: ahb-lite master plus interrupt acknowledge pin
// assumes one slave whose hreadyout is fed back as hready
`timescale 1ns/1ps
module host_model (
    input wire logic clk,
    input wire logic hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic vector_valid,
    input wire logic [7:0] vector_out,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata,
    output logic ack_n
);
    // idle bus and released acknowledge from time zero
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        ack_n = 1'b1;
    end
    // look between edges so the sampled level is settled, then take edge
    task automatic wait_ready(output logic [31:0] r);
        logic ok;
        do begin
            @(negedge clk);
            ok = hreadyout;
            r = hrdata;
            @(posedge clk);
        end while (ok !== 1'b1);
    endtask : wait_ready
    // one single word transfer, address phase then data phase
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] r);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        wait_ready(r);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready(r);
    endtask : xfer
    // acknowledge cycle; vector taken while valid stands
    task automatic acknowledge(output logic [7:0] v);
        int n;
        @(posedge clk);
        ack_n <= 1'b0;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (vector_valid !== 1'b1 && n < 20);
        v = vector_out;
        @(posedge clk);
        ack_n <= 1'b1;
        repeat (6) @(posedge clk);
    endtask : acknowledge
endmodule : host_model

// [test/tb.sv]
// self-checking bench for the interrupt arbiter
// assumes host_model drives the bus and the acknowledge pin
`timescale 1ns/1ps
module tb;
    logic clk, rst, hsel, hwrite, hrdy, hresp, ack_n, irq_n, vvalid;
    logic [31:0] haddr, hwdata, hrdata, rx_port_data, r;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [23:0] act, m;
    logic [15:0] rx_level, tx_level;
    logic [3:0] rx_error, lv, rxp, txp, popq, pushq, oh;
    logic [9:0] b, e;
    logic [6:0] thr;
    logic [11:0] pr;
    logic [7:0] vb, v, v_out, tx_data;
    logic er;
    int t, c;
    int n_push = 0;
    int num_errors = 0;
    int n_checks = 0;
    logic [31:0] seed = 32'ha784;
    multichannel_interrupt_arbiter uut (.clk(clk), .rst(rst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hrdy), .hrdata(hrdata), .hreadyout(hrdy),
        .hresp(hresp), .rx_level(rx_level), .rx_bidding(act[3:0]),
        .rx_error(rx_error), .tx_level(tx_level), .tx_bidding(act[7:4]),
        .break_change(act[11:8]), .input_change(act[15:12]),
        .flow_event(act[19:16]), .address_match(act[23:20]),
        .rx_port_data(rx_port_data), .rx_pop(rxp), .tx_push(txp),
        .tx_port_data(tx_data), .interrupt_acknowledge_in(ack_n),
        .host_interrupt_request(irq_n), .vector_out(v_out),
        .vector_valid(vvalid));
    host_model host (.clk(clk), .hreadyout(hrdy), .hrdata(hrdata),
        .vector_valid(vvalid), .vector_out(v_out), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .ack_n(ack_n));
    // xorshift keeps the run repeatable
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    // expected bid of one source
    function automatic logic [9:0] bid_of(int t, int c, logic [3:0] lv,
                                          logic er, logic [11:0] pr);
        logic [3:0] cd;
        cd = t == 2 ? 4'h2 : t == 3 ? 4'h6 : t == 4 ? 4'h7 : 4'h3;
        if (t == 0) return {lv, er, 3'b010, 2'(c)};
        if (t == 1) return {1'b0, lv, 3'b000, 2'(c)};
        return {pr[3*(t-2)+:3], cd, 1'b0, 2'(c)};
    endfunction : bid_of
    // expected vector for each modification mode
    function automatic logic [7:0] vec(int md, logic [7:0] vb,
                                       logic [9:0] w);
        case (md)
            0: return vb;
            1: return {vb[7:4], w[6:3]};
            2: return {vb[7:3], w[2:0]};
            default: return {vb[7], w[6:0]};
        endcase
    endfunction : vec
    task automatic chk(string nm, logic [31:0] ex, logic [31:0] got);
        n_checks++;
        if (got !== ex) begin
            $display("BAD %s expected %h seen %h", nm, ex, got);
            num_errors++;
        end
    endtask : chk
    task automatic wr(logic [7:0] a, logic [31:0] d);
        host.xfer(1'b1, a, d, r);
    endtask : wr
    task automatic rchk(logic [7:0] a, string nm, logic [31:0] ex);
        host.xfer(1'b0, a, 32'h0, r);
        chk(nm, ex, r);
    endtask : rchk
    task automatic conclude();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : conclude
    // two scan periods let any change be published
    task automatic settle();
        repeat (48) @(posedge clk);
    endtask : settle
    // latch the one-cycle pulses of the global ports
    always @(posedge clk) begin
        if (rxp != 4'h0) popq <= rxp;
        if (txp != 4'h0) begin
            pushq <= txp;
            n_push <= n_push + 1;
        end
    end
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // a hang is cut short well past the expected run length
    initial begin
        #500000;
        num_errors++;
        conclude();
    end
    initial begin
        rst = 1'b1;
        act = 24'h0;
        rx_level = 16'h0;
        tx_level = 16'h0;
        rx_error = 4'h0;
        rx_port_data = 32'h0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk("irq_rst", 32'h1, {31'h0, irq_n});
        chk("hresp", 32'h0, {31'h0, hresp});
        // random single sources against random or edge thresholds
        for (int i = 0; i < 12; i++) begin
            r = rnd();
            t = 32'(r[2:0]) % 6;
            c = 32'(r[4:3]);
            lv = r[8:5];
            er = r[9];
            pr = r[25:14];
            b = bid_of(t, c, lv, er, pr);
            thr = r[27] ? b[9:3] - 7'(r[28]) : {3'h0, r[13:10]};
            m = r[26] ? 24'hffffff : ~(24'h1 << (t * 4 + c));
            e = (m[t*4+c] && b[9:3] > thr) ? b : 10'h0;
            wr(8'h00, {25'h0, thr});
            wr(8'h04, {8'h0, m});
            wr(8'h0c, {20'h0, pr});
            @(posedge clk);
            act <= 24'h1 << (t * 4 + c);
            rx_level <= {4{lv}};
            tx_level <= {4{lv}};
            rx_error <= {4{er}};
            rx_port_data <= rnd();
            settle();
            @(negedge clk);
            chk("irq", {31'h0, e == 10'h0}, {31'h0, irq_n});
            rchk(8'h1c, "status", {15'h0, e != 10'h0, 6'h0, e});
            wr(8'h10, 32'h0);
            rchk(8'h10, "cir", {22'h0, e});
            rchk(8'h14, "grx", {24'h0, rx_port_data[8*e[1:0]+:8]});
            wr(8'h18, {24'h0, rx_port_data[31:24]});
            @(negedge clk);
            oh = 4'h1 << e[1:0];
            chk("ports", {16'h0, oh, oh, rx_port_data[31:24]},
                {16'h0, popq, pushq, tx_data});
            chk("npush", i + 1, n_push);
            @(posedge clk);
            act <= 24'h0;
            settle();
            rchk(8'h10, "hold", {22'h0, e});
        end
        // polled service with nothing pending reads zero
        wr(8'h00, 32'h0);
        wr(8'h10, 32'h0);
        rchk(8'h10, "poll", 32'h0);
        // equal receiver bids: the higher channel code wins
        wr(8'h04, 32'hffffff);
        @(posedge clk);
        act <= 24'h00a;
        rx_level <= 16'h5555;
        rx_error <= 4'h0;
        settle();
        wr(8'h10, 32'h0);
        rchk(8'h10, "tie", {22'h0, bid_of(0, 3, 4'h5, 1'b0, 12'h0)});
        // acknowledge cycles in every vector mode
        @(posedge clk);
        act <= 24'h1 << 10;
        wr(8'h0c, 32'h5);
        settle();
        b = bid_of(2, 2, 4'h0, 1'b0, 12'h5);
        for (int md = 0; md < 4; md++) begin
            vb = 8'(rnd());
            wr(8'h08, {24'h0, vb});
            wr(8'h00, 32'(md) << 7);
            host.acknowledge(v);
            chk("vector", {24'h0, vec(md, vb, b)}, {24'h0, v});
            rchk(8'h10, "ack_cir", {22'h0, b});
        end
        rchk(8'h20, "unmapped", 32'h0);
        conclude();
    end
endmodule : tb
